/* logic/timer_master_trigger_ctrl.sv */
// Purpose: control-two register, trigger output select, idle levels,
//          input-one combining and preload of channel control bits
// Assumes: 10 MHz kernel clock, all inputs synchronous to it
// Notes:   counting, dead-time and break logic live elsewhere
`timescale 1ns/1ps
`default_nettype none
module timer_master_trigger_ctrl (
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_clk_en,
  input  wire logic        i_awvalid,
  input  wire logic [7:0]  i_awaddr,
  output logic             o_awready,
  input  wire logic        i_wvalid,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_wready,
  output logic             o_bvalid,
  output logic      [1:0]  o_bresp,
  input  wire logic        i_bready,
  input  wire logic        i_arvalid,
  input  wire logic [7:0]  i_araddr,
  output logic             o_arready,
  output logic             o_rvalid,
  output logic      [31:0] o_rdata,
  output logic      [1:0]  o_rresp,
  input  wire logic        i_rready,
  input  wire logic        i_main_output_enable,
  input  wire logic        i_dead_time_done,
  input  wire logic [4:0]  i_oc_main,
  input  wire logic [2:0]  i_oc_compl,
  input  wire logic [2:0]  i_chan_pin,
  input  wire logic        i_sw_update_generate,
  input  wire logic        i_slave_reset,
  input  wire logic        i_counter_enable_bit,
  input  wire logic        i_gated_trigger,
  input  wire logic        i_master_slave_sync,
  input  wire logic        i_update_event,
  input  wire logic        i_chan1_capcmp_flag_set,
  input  wire logic [3:0]  i_compare_ref,
  input  wire logic        i_trigger_in,
  input  wire logic        i_sw_commutation_generate,
  output logic      [4:0]  o_out_main,
  output logic      [2:0]  o_out_compl,
  output logic             o_timer_input_one,
  output logic             o_trigger_out,
  output logic             o_trigger_in_slave,
  output logic             o_commutation_event,
  output logic      [19:0] o_chan_active
);

  // ****************************************************************
  // register bus slave
  // ****************************************************************
  logic        aw_have_r, aw_have_nxt;
  logic [7:0]  aw_addr_r, aw_addr_nxt;
  logic        w_have_r, w_have_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0]  w_strb_r, w_strb_nxt;
  logic        awready_r, awready_nxt;
  logic        wready_r, wready_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        arready_r, arready_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic [31:0] ctrl2_r, ctrl2_nxt;
  logic [19:0] chctl_r, chctl_nxt;
  logic [19:0] active;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < timer_mt_pkg::STRB_W; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  always_comb begin
    aw_have_nxt = aw_have_r;
    aw_addr_nxt = aw_addr_r;
    w_have_nxt  = w_have_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    ctrl2_nxt   = ctrl2_r;
    chctl_nxt   = chctl_r;
    if (i_awvalid && awready_r) begin
      aw_have_nxt = 1'b1;
      aw_addr_nxt = i_awaddr;
    end
    if (i_wvalid && wready_r) begin
      w_have_nxt = 1'b1;
      w_data_nxt = i_wdata;
      w_strb_nxt = i_wstrb;
    end
    if (bvalid_r && i_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_have_r && w_have_r && !bvalid_r) begin
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = timer_mt_pkg::RESP_OKAY;
      case (aw_addr_r)
        timer_mt_pkg::CTRL2_ADDR: begin
          // reserved bits stay zero whatever software writes
          ctrl2_nxt = merge(ctrl2_r, w_data_r, w_strb_r)
                      & timer_mt_pkg::CTRL2_WMASK;
        end
        timer_mt_pkg::CHCTL_ADDR: begin
          chctl_nxt = 20'(merge({12'h000, chctl_r}, w_data_r,
                                w_strb_r));
        end
        timer_mt_pkg::ACTIVE_ADDR: begin
          bresp_nxt = timer_mt_pkg::RESP_OKAY;
        end
        default: begin
          bresp_nxt = timer_mt_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (rvalid_r && i_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (i_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = timer_mt_pkg::RESP_OKAY;
      case (i_araddr)
        timer_mt_pkg::CTRL2_ADDR:  rdata_nxt = ctrl2_r;
        timer_mt_pkg::CHCTL_ADDR:  rdata_nxt = {12'h000, chctl_r};
        timer_mt_pkg::ACTIVE_ADDR: rdata_nxt = {12'h000, active};
        default: begin
          rdata_nxt = timer_mt_pkg::ZERO_WORD;
          rresp_nxt = timer_mt_pkg::RESP_SLVERR;
        end
      endcase
    end
    awready_nxt = !aw_have_nxt;
    wready_nxt  = !w_have_nxt;
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_have_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= 2'h0;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= 2'h0;
      ctrl2_r   <= timer_mt_pkg::CTRL2_RESET;
      chctl_r   <= timer_mt_pkg::CHCTL_RESET;
    end else if (i_clk_en) begin
      aw_have_r <= aw_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_have_r  <= w_have_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
      ctrl2_r   <= ctrl2_nxt;
      chctl_r   <= chctl_nxt;
    end
  end

  assign o_awready = awready_r;
  assign o_wready  = wready_r;
  assign o_bvalid  = bvalid_r;
  assign o_bresp   = bresp_r;
  assign o_arready = arready_r;
  assign o_rvalid  = rvalid_r;
  assign o_rdata   = rdata_r;
  assign o_rresp   = rresp_r;

  // ****************************************************************
  // trigger path, idle levels, input one, commutation
  // ****************************************************************
  timer_mt_pkg::master_sel_e mms;
  logic       preload_en, com_src, ti1_sel;
  logic [4:0] idle_main;
  logic [2:0] idle_compl;
  logic [4:0] main_r, main_nxt;
  logic [2:0] compl_r, compl_nxt;
  logic       ti1_r, ti1_nxt;
  logic       trigger_out_r, trigger_out_nxt;
  logic       gate_dly_r, trigger_in_dly_r, trigger_in_prev_r, srst_dly_r;
  logic       trigger_in_slave_r, trigger_in_slave_nxt;
  logic       com_r, com_nxt;

  assign mms        = timer_mt_pkg::master_sel_e'(
                        ctrl2_r[timer_mt_pkg::MMS_MSB:timer_mt_pkg::MMS_LSB]);
  assign preload_en = ctrl2_r[timer_mt_pkg::PRELOAD_BIT];
  assign com_src    = ctrl2_r[timer_mt_pkg::COMSRC_BIT];
  assign ti1_sel    = ctrl2_r[timer_mt_pkg::INPUT_ONE_SOURCE_SEL_BIT];

  genvar g;
  generate
    for (g = 0; g < timer_mt_pkg::N_COMPL; g = g + 1) begin : g_idle
      assign idle_main[g]  = ctrl2_r[timer_mt_pkg::IDLE_MAIN1_BIT
                                     + g*timer_mt_pkg::IDLE_STEP];
      assign idle_compl[g] = ctrl2_r[timer_mt_pkg::IDLE_COMP1_BIT
                                     + g*timer_mt_pkg::IDLE_STEP];
    end
  endgenerate
  assign idle_main[3] = ctrl2_r[timer_mt_pkg::IDLE_MAIN4_BIT];
  assign idle_main[4] = ctrl2_r[timer_mt_pkg::IDLE_MAIN5_BIT];

  always_comb begin
    // outputs sit low between disable and the end of dead-time
    if (i_main_output_enable) begin
      main_nxt  = i_oc_main;
      compl_nxt = i_oc_compl;
    end else if (i_dead_time_done) begin
      main_nxt  = idle_main;
      compl_nxt = idle_compl;
    end else begin
      main_nxt  = 5'h00;
      compl_nxt = 3'h0;
    end
    ti1_nxt = ti1_sel ? ^i_chan_pin : i_chan_pin[0];
    // sync set: trigger input goes out late so that slaves, which see
    // the trigger output one cycle late, stay aligned with this timer
    trigger_in_slave_nxt = i_master_slave_sync ? trigger_in_dly_r
                                         : i_trigger_in;
    com_nxt = i_sw_commutation_generate
              || (com_src && i_trigger_in && !trigger_in_prev_r);
    case (mms)
      timer_mt_pkg::MMS_RESET:
        trigger_out_nxt = i_sw_update_generate || srst_dly_r;
      timer_mt_pkg::MMS_ENABLE:
        trigger_out_nxt = i_counter_enable_bit
                   || (i_master_slave_sync ? i_gated_trigger
                                           : gate_dly_r);
      timer_mt_pkg::MMS_UPDATE: trigger_out_nxt = i_update_event;
      timer_mt_pkg::MMS_CPULSE:
        trigger_out_nxt = i_chan1_capcmp_flag_set;
      timer_mt_pkg::MMS_REF1:   trigger_out_nxt = i_compare_ref[0];
      timer_mt_pkg::MMS_REF2:   trigger_out_nxt = i_compare_ref[1];
      timer_mt_pkg::MMS_REF3:   trigger_out_nxt = i_compare_ref[2];
      timer_mt_pkg::MMS_REF4:   trigger_out_nxt = i_compare_ref[3];
      default:                  trigger_out_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      main_r       <= 5'h00;
      compl_r      <= 3'h0;
      ti1_r        <= 1'b0;
      trigger_out_r       <= 1'b0;
      gate_dly_r   <= 1'b0;
      trigger_in_dly_r   <= 1'b0;
      trigger_in_prev_r  <= 1'b0;
      srst_dly_r   <= 1'b0;
      trigger_in_slave_r <= 1'b0;
      com_r        <= 1'b0;
    end else if (i_clk_en) begin
      main_r       <= main_nxt;
      compl_r      <= compl_nxt;
      ti1_r        <= ti1_nxt;
      trigger_out_r       <= trigger_out_nxt;
      gate_dly_r   <= i_gated_trigger;
      trigger_in_dly_r   <= i_trigger_in;
      trigger_in_prev_r  <= i_trigger_in;
      srst_dly_r   <= i_slave_reset;
      trigger_in_slave_r <= trigger_in_slave_nxt;
      com_r        <= com_nxt;
    end
  end

  chan_ctrl_shadow u_shadow (
    .i_sys_clk    (i_sys_clk),
    .i_resetn     (i_resetn),
    .i_clk_en     (i_clk_en),
    .i_preload_en (preload_en),
    .i_com        (com_r),
    .i_staged     (chctl_r),
    .o_active     (active)
  );

  assign o_out_main          = main_r;
  assign o_out_compl         = compl_r;
  assign o_timer_input_one   = ti1_r;
  assign o_trigger_out       = trigger_out_r;
  assign o_trigger_in_slave  = trigger_in_slave_r;
  assign o_commutation_event = com_r;
  assign o_chan_active       = active;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_idle;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_clk_en && !i_main_output_enable && i_dead_time_done) |=>
        (o_out_compl[0] == $past(idle_compl[0])
         && o_out_main == $past(idle_main));
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle levels not driven");

  property p_ti1;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_clk_en && ti1_sel) |=> (o_timer_input_one == ^$past(i_chan_pin));
  endproperty
  a_ti1: assert property (p_ti1)
    else $error("input one is not the XOR of the pins");

  property p_slave_rst;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_clk_en && mms == timer_mt_pkg::MMS_RESET && i_slave_reset)
        ##1 (i_clk_en && mms == timer_mt_pkg::MMS_RESET) |=> o_trigger_out;
  endproperty
  a_slave_rst: assert property (p_slave_rst)
    else $error("slave reset pulse missing");

  property p_enable;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_clk_en && mms == timer_mt_pkg::MMS_ENABLE && i_counter_enable_bit)
        |=> o_trigger_out;
  endproperty
  a_enable: assert property (p_enable)
    else $error("counter enable not on trigger out");

  property p_cpulse;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_clk_en && mms == timer_mt_pkg::MMS_CPULSE) |=>
        (o_trigger_out == $past(i_chan1_capcmp_flag_set));
  endproperty
  a_cpulse: assert property (p_cpulse)
    else $error("compare pulse mismatch");

  property p_ref;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_clk_en && ctrl2_r[timer_mt_pkg::MMS_MSB]) |=>
        (o_trigger_out == $past(i_compare_ref[mms[1:0]]));
  endproperty
  a_ref: assert property (p_ref)
    else $error("trigger out does not follow compare reference");

  property p_com_sw_only;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_clk_en && !com_src && !i_sw_commutation_generate) |=>
        !o_commutation_event;
  endproperty
  a_com_sw_only: assert property (p_com_sw_only)
    else $error("commutation without software request");

  property p_reserved;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      ##1 ((ctrl2_r & ~timer_mt_pkg::CTRL2_WMASK) == 32'h0000_0000);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved control bits set");

  c_write: cover property (@(posedge i_sys_clk) bvalid_r && i_bready);
  c_com:   cover property (@(posedge i_sys_clk) com_r && preload_en);
  c_trigger_out:  cover property (@(posedge i_sys_clk) trigger_out_r ##1 !trigger_out_r);

endmodule
`default_nettype wire

/* logic/timer_mt_pkg.sv */
// Purpose: shared constants of the master trigger and control-two block
// Assumes: AXI4-Lite with 8-bit byte addresses and 32-bit data
// Notes:   every offset, bit position, mask and code is named here
package timer_mt_pkg;

  // ****************************************************************
  // bus
  // ****************************************************************
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam int          STRB_W         = 4;
  localparam logic [7:0]  CTRL2_ADDR     = 8'h04;
  localparam logic [7:0]  CHCTL_ADDR     = 8'h20;
  localparam logic [7:0]  ACTIVE_ADDR    = 8'h24;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [31:0] ZERO_WORD      = 32'h0000_0000;

  // ****************************************************************
  // control two layout
  // ****************************************************************
  localparam logic [31:0] CTRL2_RESET    = 32'h0000_0000;
  localparam logic [31:0] CTRL2_WMASK    = 32'h0001_7FF5;
  localparam int          PRELOAD_BIT    = 0;
  localparam int          COMSRC_BIT     = 2;
  localparam int          MMS_LSB        = 4;
  localparam int          MMS_MSB        = 6;
  localparam int          INPUT_ONE_SOURCE_SEL_BIT     = 7;
  localparam int          IDLE_MAIN1_BIT = 8;
  localparam int          IDLE_COMP1_BIT = 9;
  localparam int          IDLE_STEP      = 2;
  localparam int          IDLE_MAIN4_BIT = 14;
  localparam int          IDLE_MAIN5_BIT = 16;

  // ****************************************************************
  // channel control staging
  // ****************************************************************
  localparam int          N_MAIN         = 5;
  localparam int          N_COMPL        = 3;
  localparam int          N_CHCTL        = 4;
  localparam int          CH_FIELD_W     = 5;
  localparam int          CHCTL_W        = 20;
  localparam logic [19:0] CHCTL_RESET    = 20'h0_0000;

  typedef enum logic [2:0] {
    MMS_RESET  = 3'b000,
    MMS_ENABLE = 3'b001,
    MMS_UPDATE = 3'b010,
    MMS_CPULSE = 3'b011,
    MMS_REF1   = 3'b100,
    MMS_REF2   = 3'b101,
    MMS_REF3   = 3'b110,
    MMS_REF4   = 3'b111
  } master_sel_e;

endpackage

/* logic/chan_ctrl_shadow.sv */
// Purpose: active copies of channel enable, complementary enable, mode
// Assumes: i_com is a one-cycle commutation pulse
// Notes:   channel 4 has no complementary output and never waits
`timescale 1ns/1ps
`default_nettype none
module chan_ctrl_shadow (
  input  wire logic        i_sys_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_clk_en,
  input  wire logic        i_preload_en,
  input  wire logic        i_com,
  input  wire logic [19:0] i_staged,
  output logic      [19:0] o_active
);

  // ****************************************************************
  // per-channel copy
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < timer_mt_pkg::N_CHCTL; g = g + 1) begin : g_ch
      logic [4:0] act_r;
      logic [4:0] act_nxt;
      logic       upd;
      always_comb begin
        if (g < timer_mt_pkg::N_COMPL) begin
          upd = !i_preload_en || i_com;
        end else begin
          upd = 1'b1;
        end
        act_nxt = upd ? i_staged[g*timer_mt_pkg::CH_FIELD_W +:
                                 timer_mt_pkg::CH_FIELD_W] : act_r;
      end
      always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
          act_r <= 5'h00;
        end else if (i_clk_en) begin
          act_r <= act_nxt;
        end
      end
      assign o_active[g*timer_mt_pkg::CH_FIELD_W +:
                      timer_mt_pkg::CH_FIELD_W] = act_r;
    end
  endgenerate

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_hold_preload;
    @(posedge i_sys_clk) disable iff (!i_resetn)
      (i_clk_en && i_preload_en && !i_com) |=>
        (o_active[14:0] == $past(o_active[14:0]));
  endproperty
  a_hold_preload: assert property (p_hold_preload)
    else $error("active copy changed without commutation");

endmodule
`default_nettype wire

/* verif/slave_timer_model.sv */
// Purpose: slave timer fed by trigger out, counts its rising edges
// Assumes: trigger out is synchronous to the kernel clock
// Notes:   only the prescaled-clock use of trigger out is modelled
`timescale 1ns/1ps
`default_nettype none
module slave_timer_model (
  input  wire logic i_sys_clk,
  input  wire logic i_resetn,
  input  wire logic i_trigger_out,
  output var  int   o_ticks
);
  logic last_r;
  // edge count, so merged pulses would show as a missing tick
  always_ff @(posedge i_sys_clk) begin
    last_r <= i_trigger_out;
    if (!i_resetn)
      o_ticks <= 0;
    else if (i_trigger_out && !last_r)
      o_ticks <= o_ticks + 1;
  end
endmodule
`default_nettype wire

/* verif/timer_master_trigger_ctrl_bench.sv */
// Purpose: self-checking bench of the master trigger control block
// Assumes: clock enable dropped once to check the freeze, one access
//          at a time
// Notes:   expectations come from the control-two layout constants
`timescale 1ns/1ps
`default_nettype none
module timer_master_trigger_ctrl_bench;
  logic        clk, rstn, awv, wv, bre, arv, rre, moe, dtd, srst;
  logic        ceb, gate, sync, trig, swcom, awrdy, wrdy, bv, arrdy;
  logic        rv, ti1, tout, tslv, commutation_event, cen;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd;
  logic [3:0]  ws, cref;
  logic [1:0]  br, rr;
  logic [4:0]  ocm, om;
  logic [2:0]  occ, oc, pin, pls;
  logic [19:0] act;
  int          num_errors, checked, ticks, t0;

  timer_master_trigger_ctrl dut (
    .i_sys_clk(clk), .i_resetn(rstn), .i_clk_en(cen),
    .i_awvalid(awv), .i_awaddr(awa), .o_awready(awrdy),
    .i_wvalid(wv), .i_wdata(wd), .i_wstrb(ws), .o_wready(wrdy),
    .o_bvalid(bv), .o_bresp(br), .i_bready(bre),
    .i_arvalid(arv), .i_araddr(ara), .o_arready(arrdy),
    .o_rvalid(rv), .o_rdata(rd), .o_rresp(rr), .i_rready(rre),
    .i_main_output_enable(moe), .i_dead_time_done(dtd),
    .i_oc_main(ocm), .i_oc_compl(occ), .i_chan_pin(pin),
    .i_sw_update_generate(pls[0]), .i_slave_reset(srst),
    .i_counter_enable_bit(ceb), .i_gated_trigger(gate),
    .i_master_slave_sync(sync), .i_update_event(pls[1]),
    .i_chan1_capcmp_flag_set(pls[2]), .i_compare_ref(cref),
    .i_trigger_in(trig), .i_sw_commutation_generate(swcom),
    .o_out_main(om), .o_out_compl(oc), .o_timer_input_one(ti1),
    .o_trigger_out(tout), .o_trigger_in_slave(tslv),
    .o_commutation_event(commutation_event), .o_chan_active(act)
  );

  slave_timer_model partner (
    .i_sys_clk(clk), .i_resetn(rstn), .i_trigger_out(tout),
    .o_ticks(ticks)
  );

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  // ******************************
  // bus and check tasks
  // ******************************
  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic lost(input int n);
    if (n >= 40) begin
      num_errors++;
      close_out();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    int n;
    n = 0;
    @(posedge clk);
    awv <= 1'h1;
    awa <= a;
    wv <= 1'h1;
    wd <= d;
    bre <= 1'h1;
    do begin
      @(posedge clk);
      if (awrdy && awv)
        awv <= 1'h0;
      if (wrdy && wv)
        wv <= 1'h0;
      n++;
    end while (bv !== 1'h1 && n < 40);
    bre <= 1'h0;
    lost(n);
    chk(br, e);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    arv <= 1'h1;
    ara <= a;
    rre <= 1'h1;
    do begin
      @(posedge clk);
      if (arrdy && arv)
        arv <= 1'h0;
      n++;
    end while (rv !== 1'h1 && n < 40);
    rre <= 1'h0;
    lost(n);
    chk(rd, e);
    chk(rr, er);
  endtask

  // ******************************
  // main sequence
  // ******************************
  initial begin
    {rstn, awv, wv, bre, arv, rre, moe, srst, ceb, gate} = '0;
    {sync, trig, swcom, awa, ara, wd, cref, ocm, occ, pls} = '0;
    ws = 4'hF;
    cen = 1'h1;
    dtd = 1'h1;
    pin = 3'h3;
    num_errors = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    step(2);
    rdc(timer_mt_pkg::CTRL2_ADDR, timer_mt_pkg::CTRL2_RESET,
        timer_mt_pkg::RESP_OKAY);
    rdc(8'h10, timer_mt_pkg::ZERO_WORD, timer_mt_pkg::RESP_SLVERR);
    wr(8'h10, 32'hFFFF_FFFF, timer_mt_pkg::RESP_SLVERR);
    wr(timer_mt_pkg::CTRL2_ADDR, timer_mt_pkg::CTRL2_WMASK,
       timer_mt_pkg::RESP_OKAY);
    rdc(timer_mt_pkg::CTRL2_ADDR, timer_mt_pkg::CTRL2_WMASK,
        timer_mt_pkg::RESP_OKAY);
    @(posedge clk) moe <= 1'h1;
    ocm <= 5'h15;
    occ <= 3'h5;
    step(1);
    chk(om, 32'h15);
    chk(oc, 32'h5);
    // outputs sit low until the dead-time has run out
    @(posedge clk) moe <= 1'h0;
    dtd <= 1'h0;
    step(1);
    chk({om, oc}, 32'h0);
    @(posedge clk) dtd <= 1'h1;
    step(1);
    chk({om, oc}, 32'hFF);
    for (int i = 0; i < 2; i++) begin
      wr(timer_mt_pkg::CTRL2_ADDR, i ? 32'h0000_2A00 : 32'h0001_5500,
         timer_mt_pkg::RESP_OKAY);
      step(2);
      chk(om, i ? 32'h0 : 32'h1F);
      chk(oc, i ? 32'h7 : 32'h0);
      wr(timer_mt_pkg::CTRL2_ADDR, i ? 32'h0000_0080 : 32'h0,
         timer_mt_pkg::RESP_OKAY);
      step(2);
      chk(ti1, i ? 32'h0 : 32'h1);
    end
    for (int i = 4; i < 8; i++) begin
      wr(timer_mt_pkg::CTRL2_ADDR, 32'(i) << 4, timer_mt_pkg::RESP_OKAY);
      @(posedge clk) cref <= 4'h1 << (i - 4);
      step(1);
      chk(tout, 32'h1);
      @(posedge clk) cref <= ~(4'h1 << (i - 4));
      step(1);
      chk(tout, 32'h0);
    end
    // pulse sources in mode order 000, 010, 011
    for (int j = 0; j < 3; j++) begin
      wr(timer_mt_pkg::CTRL2_ADDR, j ? 32'(j + 1) << 4 : 32'h0,
         timer_mt_pkg::RESP_OKAY);
      t0 = ticks;
      repeat (2) begin
        @(posedge clk) pls[j] <= 1'h1;
        @(posedge clk) pls[j] <= 1'h0;
        #1 chk(tout, 32'h1);
        step(1);
        chk(tout, 32'h0);
      end
      chk(ticks, t0 + 2);
    end
    wr(timer_mt_pkg::CTRL2_ADDR, 32'h0, timer_mt_pkg::RESP_OKAY);
    @(posedge clk) srst <= 1'h1;
    @(posedge clk) srst <= 1'h0;
    #1 chk(tout, 32'h0);
    step(1);
    chk(tout, 32'h1);
    step(1);
    chk(tout, 32'h0);
    wr(timer_mt_pkg::CTRL2_ADDR, 32'h0000_0010, timer_mt_pkg::RESP_OKAY);
    @(posedge clk) ceb <= 1'h1;
    cen <= 1'h0;
    step(2);
    chk(tout, 32'h0); // frozen while the clock enable is low
    @(posedge clk) cen <= 1'h1;
    step(1);
    chk(tout, 32'h1);
    @(posedge clk) ceb <= 1'h0;
    step(1);
    chk(tout, 32'h0);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk) sync <= 1'(s);
      @(posedge clk) gate <= 1'h1;
      trig <= 1'h1;
      step(1);
      chk(tout, s ? 32'h1 : 32'h0);
      chk(tslv, s ? 32'h0 : 32'h1);
      step(1);
      chk(tout, 32'h1);
      chk(tslv, 32'h1);
      @(posedge clk) gate <= 1'h0;
      trig <= 1'h0;
      sync <= 1'h0;
      step(2);
    end
    wr(timer_mt_pkg::CTRL2_ADDR, 32'h0, timer_mt_pkg::RESP_OKAY);
    wr(timer_mt_pkg::CHCTL_ADDR, 32'hF_FFFF, timer_mt_pkg::RESP_OKAY);
    step(1);
    chk(act, 32'hF_FFFF);
    wr(timer_mt_pkg::CTRL2_ADDR, 32'h1, timer_mt_pkg::RESP_OKAY);
    wr(timer_mt_pkg::CHCTL_ADDR, 32'h0, timer_mt_pkg::RESP_OKAY);
    step(1);
    chk(act, 32'h0_7FFF);
    @(posedge clk) trig <= 1'h1;
    step(1);
    chk(commutation_event, 32'h0);
    @(posedge clk) swcom <= 1'h1;
    @(posedge clk) swcom <= 1'h0;
    #1 chk(commutation_event, 32'h1);
    step(1);
    chk(act, 32'h0);
    @(posedge clk) trig <= 1'h0;
    wr(timer_mt_pkg::CTRL2_ADDR, 32'h5, timer_mt_pkg::RESP_OKAY);
    wr(timer_mt_pkg::CHCTL_ADDR, 32'hF_FFFF, timer_mt_pkg::RESP_OKAY);
    step(1);
    chk(act, 32'hF_8000);
    @(posedge clk) trig <= 1'h1;
    step(1);
    chk(commutation_event, 32'h1);
    step(1);
    chk(act, 32'hF_FFFF);
    close_out();
  end
endmodule
`default_nettype wire
